// *** src/dma_chan_pkg.sv ***
// Purpose: shared constants for one dma channel
// Assumes: byte-wide transfers, apb register access
// Notes:   offsets are byte addresses of 32-bit words
package dma_chan_pkg;
	localparam int          ADDR_W   = 8;
	localparam int          CNT_W    = 24;
	// register offsets
	localparam logic [7:0]  OFS_CTRL = 8'h00;
	localparam logic [7:0]  OFS_BREQ = 8'h04;
	localparam logic [7:0]  OFS_BTGT = 8'h08;
	localparam logic [7:0]  OFS_BCNT = 8'h0C;
	localparam logic [7:0]  OFS_CREQ = 8'h10;
	localparam logic [7:0]  OFS_CTGT = 8'h14;
	localparam logic [7:0]  OFS_CCNT = 8'h18;
	localparam logic [7:0]  OFS_STAT = 8'h1C;
	// control fields
	localparam int          CTRL_EN    = 0;
	localparam int          CTRL_DIR   = 1;
	localparam int          CTRL_PROC  = 2;
	localparam int          CTRL_RSTEP = 4;
	localparam int          CTRL_TSTEP = 6;
	localparam logic        DIR_READ   = 1'b0;
	// status fields
	localparam int          ST_BUSY  = 0;
	localparam int          ST_STOP  = 1;
	localparam int          ST_EMPTY = 2;
	localparam int          ST_IRQ   = 3;
	// buffer processes
	localparam logic [1:0]  PROC_SINGLE = 2'h0;
	localparam logic [1:0]  PROC_AUTO   = 2'h1;
	localparam logic [1:0]  PROC_CHAIN  = 2'h2;
	// address stepping
	localparam logic [1:0]  STEP_INC  = 2'h0;
	localparam logic [1:0]  STEP_DEC  = 2'h1;
	// values after reset
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [31:0] WORD_RST = 32'h00000000;
	localparam logic [1:0]  SYNC_RST = 2'h2;
endpackage

// *** src/step_if.sv ***
// Purpose: carries one address stepper's controls and result
// Assumes: same clock as the channel
// Notes:   ctl side is the channel, stepper side holds the address
interface step_if;
	logic [31:0] base;
	logic [1:0]  mode;
	logic        load;
	logic        adv;
	logic [31:0] cur;
	modport ctl (output base, output mode, output load, output adv, input cur);
	modport stepper (input base, input mode, input load, input adv, output cur);
endinterface

// *** src/sync2.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to ref_clk
// Notes:   only the second stage may be read
module sync2 #(
	parameter int         WIDTH = 2,
	parameter logic [1:0] RST   = 2'h0
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	// data
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] q_reg;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= RST[WIDTH-1:0];
			q_reg    <= RST[WIDTH-1:0];
		end else begin
			meta_reg <= d;
			q_reg    <= meta_reg;
		end
	end

	assign q = q_reg;
endmodule

// *** src/addr_step.sv ***
// Purpose: current address register with inc/dec/hold stepping
// Assumes: load wins over advance
// Notes:   mode code 3 holds like code 2
module addr_step (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset_n,
	// control
	step_if.stepper   s
);
	logic [31:0] cur_reg;
	logic [31:0] cur_next;
	wire  [31:0] stepped;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	assign stepped = (s.mode == dma_chan_pkg::STEP_INC) ? cur_reg + 32'h00000001 :
		(s.mode == dma_chan_pkg::STEP_DEC) ? cur_reg - 32'h00000001 : cur_reg; // [RULE3]
	assign cur_next = s.load ? s.base : (s.adv ? stepped : cur_reg);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur_reg <= dma_chan_pkg::WORD_RST;
		end else begin
			cur_reg <= cur_next; // [RULE17]
		end
	end

	assign s.cur = cur_reg;

	step_inc_a: assert property ( // [RULE3]
		s.adv && !s.load && s.mode == dma_chan_pkg::STEP_INC |=> cur_reg == $past(cur_reg) + 32'h00000001)
		else $error("address did not increment");
	step_hold_a: assert property ( // [RULE3]
		!s.adv && !s.load |=> $stable(cur_reg))
		else $error("address moved without an access");
endmodule

// *** src/dma_chan.sv ***
// Purpose: one dma channel with buffer processes and apb registers
// Assumes: byte transfers; requester and target buses ack on ref_clk
// Notes:   writing control reprograms the channel and reloads current
//
// Functional notes
// RULE1: read moves target data to requester
// RULE2: write moves requester data to target
// RULE3: each address steps inc, dec or hold
// RULE4: channel state depends on no other channel
// RULE5: single buffer ends on expiry or end input
// RULE6: ended single buffer waits for reprogramming
// RULE7: auto-initialize reloads current from base on end
// RULE8: auto-initialize repeats until disabled or reprogrammed
// RULE9: chaining restarts from waiting base registers
// RULE10: chain reload marks base empty, raises interrupt
// RULE11: host refills base before count expires
// RULE12: expiry with empty base stops the chain
// RULE13: end input in chaining counts as expiry
// RULE14: base target top byte write marks full
// RULE15: host writes target address base last
// RULE16: chaining runs until reprogrammed or out
// RULE17: device never changes base registers
// RULE18: count decrements per byte, expires past zero
// RULE19: peripheral end input terminates current buffer
// RULE20: reprogramming clears base empty and interrupt
module dma_chan (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// peripheral pins
	input  wire logic        dreq,
	input  wire logic        process_end_n,
	// requester bus
	output logic      [31:0] req_addr,
	output logic             req_stb,
	output logic             req_wr,
	input  wire logic [7:0]  req_rdata,
	input  wire logic        req_ack,
	// target bus
	output logic      [31:0] tgt_addr,
	output logic             tgt_stb,
	output logic             tgt_wr,
	input  wire logic [7:0]  tgt_rdata,
	input  wire logic        tgt_ack,
	// shared write data and interrupt
	output logic      [7:0]  xfer_wdata,
	output logic             chain_refill_irq
);
	typedef enum logic [1:0] {S_IDLE, S_SRC, S_DST} state_e;
	state_e                              state_reg;
	logic   [7:0]                        ctrl_reg;
	logic   [31:0]                       base_req_reg;
	logic   [31:0]                       base_tgt_reg;
	logic   [dma_chan_pkg::CNT_W-1:0]    base_cnt_reg;
	logic   [dma_chan_pkg::CNT_W-1:0]    cur_cnt_reg;
	logic   [dma_chan_pkg::CNT_W-1:0]    cur_cnt_next;
	logic                                stopped_reg;
	logic                                empty_reg;
	logic                                irq_reg;
	logic   [7:0]                        data_reg;
	logic                                req_stb_reg;
	logic                                req_wr_reg;
	logic                                tgt_stb_reg;
	logic                                tgt_wr_reg;
	logic   [31:0]                       prdata_reg;
	logic                                pready_reg;
	logic                                pslverr_reg;
	logic   [1:0]                        pins_s;
	logic                                eop_prev_reg;
	logic                                eop_pend_reg;

	step_if req_st ();
	step_if tgt_st ();
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	sync2 #(.WIDTH(2), .RST(dma_chan_pkg::SYNC_RST)) pin_sync (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.d       ({process_end_n, dreq}),
		.q       (pins_s)
	);

	// apb decode
	wire        setup    = psel & ~penable;
	wire        access   = psel & penable & pready_reg;
	wire        apb_wr   = access & pwrite;
	wire        hit_ctrl = paddr == dma_chan_pkg::OFS_CTRL;
	wire        hit_breq = paddr == dma_chan_pkg::OFS_BREQ;
	wire        hit_btgt = paddr == dma_chan_pkg::OFS_BTGT;
	wire        hit_bcnt = paddr == dma_chan_pkg::OFS_BCNT;
	wire        hit_creq = paddr == dma_chan_pkg::OFS_CREQ;
	wire        hit_ctgt = paddr == dma_chan_pkg::OFS_CTGT;
	wire        hit_ccnt = paddr == dma_chan_pkg::OFS_CCNT;
	wire        hit_stat = paddr == dma_chan_pkg::OFS_STAT;
	wire        hit_any  = hit_ctrl | hit_breq | hit_btgt | hit_bcnt | hit_creq | hit_ctgt | hit_ccnt | hit_stat;
	wire        ctrl_wr  = apb_wr & hit_ctrl;
	wire        msb_wr   = apb_wr & hit_btgt & pstrb[3];

	// control fields
	wire        enable   = ctrl_reg[dma_chan_pkg::CTRL_EN];
	wire        dir_wr   = ctrl_reg[dma_chan_pkg::CTRL_DIR] != dma_chan_pkg::DIR_READ;
	wire  [1:0] proc     = ctrl_reg[dma_chan_pkg::CTRL_PROC +: 2];
	wire        is_auto  = proc == dma_chan_pkg::PROC_AUTO;
	wire        is_chain = proc == dma_chan_pkg::PROC_CHAIN;
	wire        is_single = !is_auto && !is_chain;

	// transfer decode: write takes from the requester, read from the target
	wire        dreq_s   = pins_s[0];
	wire        eop      = ~pins_s[1];
	wire        eop_hit  = eop_pend_reg | (eop & ~eop_prev_reg);
	wire        run      = enable & ~stopped_reg;
	wire        src_ack  = dir_wr ? req_ack : tgt_ack; // [RULE1] [RULE2]
	wire        dst_ack  = dir_wr ? tgt_ack : req_ack;
	wire  [7:0] src_data = dir_wr ? req_rdata : tgt_rdata;
	wire        byte_done = state_reg == S_DST && dst_ack;
	wire        cnt_zero = cur_cnt_reg == '0;
	// end event waits for a byte boundary; a pin held active ends one buffer only
	wire        term     = run && ((byte_done && (cnt_zero || eop_hit)) || (state_reg == S_IDLE && eop_hit)); // [RULE19]
	wire        reload   = term && !ctrl_wr && (is_auto || (is_chain && !empty_reg)); // [RULE7] [RULE8] [RULE9] [RULE13]
	wire        halt     = term && !reload; // [RULE5] [RULE12]
	wire        start    = state_reg == S_IDLE && run && dreq_s && !eop && !ctrl_wr;

	// register read mux
	wire [31:0] status   = {28'h0000000, irq_reg, empty_reg, stopped_reg, state_reg != S_IDLE};
	wire [31:0] rd_mux   = hit_ctrl ? {24'h000000, ctrl_reg} :
		hit_breq ? base_req_reg :
		hit_btgt ? base_tgt_reg :
		hit_bcnt ? {8'h00, base_cnt_reg} :
		hit_creq ? req_st.cur :
		hit_ctgt ? tgt_st.cur :
		hit_ccnt ? {8'h00, cur_cnt_reg} :
		hit_stat ? status : dma_chan_pkg::WORD_RST;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction
	wire [31:0] bcnt_merged = merge({8'h00, base_cnt_reg}, pwdata, pstrb);

	// address steppers; reprogram or reload copies base into current
	assign req_st.base = base_req_reg;
	assign req_st.mode = ctrl_reg[dma_chan_pkg::CTRL_RSTEP +: 2];
	assign req_st.load = ctrl_wr | reload; // [RULE7] [RULE9]
	assign req_st.adv  = byte_done;
	assign tgt_st.base = base_tgt_reg;
	assign tgt_st.mode = ctrl_reg[dma_chan_pkg::CTRL_TSTEP +: 2];
	assign tgt_st.load = ctrl_wr | reload;
	assign tgt_st.adv  = byte_done;

	addr_step req_step (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.s       (req_st.stepper)
	);

	addr_step tgt_step (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.s       (tgt_st.stepper)
	);

	assign cur_cnt_next = (ctrl_wr || reload) ? base_cnt_reg :
		byte_done ? cur_cnt_reg - 24'h000001 : cur_cnt_reg; // [RULE18]

	// apb answer: pready one cycle after setup, so no wait states
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= dma_chan_pkg::WORD_RST;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~hit_any;
			prdata_reg  <= setup ? rd_mux : dma_chan_pkg::WORD_RST;
		end
	end

	// base registers change only by software writes
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg     <= dma_chan_pkg::CTRL_RST;
			base_req_reg <= dma_chan_pkg::WORD_RST;
			base_tgt_reg <= dma_chan_pkg::WORD_RST;
			base_cnt_reg <= '0;
		end else begin
			if (ctrl_wr && pstrb[0]) begin
				ctrl_reg <= pwdata[7:0];
			end
			if (apb_wr && hit_breq) begin
				base_req_reg <= merge(base_req_reg, pwdata, pstrb); // [RULE17]
			end
			if (apb_wr && hit_btgt) begin
				base_tgt_reg <= merge(base_tgt_reg, pwdata, pstrb);
			end
			if (apb_wr && hit_bcnt) begin
				base_cnt_reg <= bcnt_merged[dma_chan_pkg::CNT_W-1:0];
			end
		end
	end

	// process state; everything here is private to this channel [RULE4]
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur_cnt_reg <= '0;
			stopped_reg <= 1'b1;
			empty_reg   <= 1'b0;
			irq_reg     <= 1'b0;
			eop_prev_reg <= 1'b0;
			eop_pend_reg <= 1'b0;
		end else begin
			cur_cnt_reg <= cur_cnt_next;
			eop_prev_reg <= eop;
			eop_pend_reg <= eop_hit && !term && !ctrl_wr; // [RULE19]
			if (ctrl_wr) begin
				stopped_reg <= 1'b0; // [RULE6]
			end else if (halt) begin
				stopped_reg <= 1'b1; // [RULE5] [RULE12] [RULE16]
			end
			// the chain reload sets and wins over a same-cycle clear
			if (reload && is_chain) begin
				empty_reg <= 1'b1; // [RULE10]
				irq_reg   <= 1'b1;
			end else if (ctrl_wr || msb_wr || !is_chain) begin
				empty_reg <= 1'b0; // [RULE14] [RULE20]
				irq_reg   <= 1'b0;
			end
		end
	end

	// byte mover: source access, then destination access
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg   <= S_IDLE;
			data_reg    <= 8'h00;
			req_stb_reg <= 1'b0;
			req_wr_reg  <= 1'b0;
			tgt_stb_reg <= 1'b0;
			tgt_wr_reg  <= 1'b0;
		end else if (ctrl_wr) begin
			state_reg   <= S_IDLE;
			req_stb_reg <= 1'b0;
			tgt_stb_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				S_IDLE: begin
					if (start) begin
						state_reg   <= S_SRC;
						req_stb_reg <= dir_wr; // [RULE2]
						tgt_stb_reg <= !dir_wr; // [RULE1]
						req_wr_reg  <= 1'b0;
						tgt_wr_reg  <= 1'b0;
					end
				end
				S_SRC: begin
					if (src_ack) begin
						state_reg   <= S_DST;
						data_reg    <= src_data;
						req_stb_reg <= !dir_wr; // [RULE1]
						tgt_stb_reg <= dir_wr; // [RULE2]
						req_wr_reg  <= !dir_wr;
						tgt_wr_reg  <= dir_wr;
					end
				end
				S_DST: begin
					if (dst_ack) begin
						state_reg   <= S_IDLE;
						req_stb_reg <= 1'b0;
						tgt_stb_reg <= 1'b0;
					end
				end
			endcase
		end
	end

	assign prdata           = prdata_reg;
	assign pready           = pready_reg;
	assign pslverr          = pslverr_reg;
	assign req_addr         = req_st.cur;
	assign tgt_addr         = tgt_st.cur;
	assign req_stb          = req_stb_reg;
	assign req_wr           = req_wr_reg;
	assign tgt_stb          = tgt_stb_reg;
	assign tgt_wr           = tgt_wr_reg;
	assign xfer_wdata       = data_reg;
	assign chain_refill_irq = irq_reg;

	single_stop_a: assert property ( // [RULE5]
		term && is_single && !ctrl_wr |=> stopped_reg && state_reg == S_IDLE)
		else $error("single buffer did not stop");
	stop_hold_a: assert property ( // [RULE6]
		stopped_reg && !ctrl_wr |=> stopped_reg ##1 !req_stb_reg && !tgt_stb_reg)
		else $error("stopped channel restarted");
	auto_reload_a: assert property ( // [RULE7]
		term && is_auto && !ctrl_wr |=> cur_cnt_reg == $past(base_cnt_reg) && !stopped_reg)
		else $error("auto reload missing");
	chain_mark_a: assert property ( // [RULE10]
		term && is_chain && !empty_reg && !ctrl_wr |=> empty_reg && chain_refill_irq)
		else $error("chain reload did not mark empty");
	chain_out_a: assert property ( // [RULE12]
		term && is_chain && empty_reg && !ctrl_wr |=> stopped_reg)
		else $error("empty chain kept running");
	msb_full_a: assert property ( // [RULE14]
		msb_wr && !reload && is_chain |=> !empty_reg && !chain_refill_irq)
		else $error("top byte write did not mark full");
	cnt_step_a: assert property ( // [RULE18]
		byte_done && !term && !ctrl_wr |=> cur_cnt_reg == $past(cur_cnt_reg) - 24'h000001)
		else $error("count did not decrement");
	read_dir_a: assert property ( // [RULE1]
		state_reg == S_SRC && !dir_wr && !ctrl_wr && tgt_ack |=> req_stb && req_wr && xfer_wdata == $past(tgt_rdata))
		else $error("read did not deliver to requester");
	write_dir_a: assert property ( // [RULE2]
		state_reg == S_SRC && dir_wr && !ctrl_wr && req_ack |=> tgt_stb && tgt_wr && xfer_wdata == $past(req_rdata))
		else $error("write did not deliver to target");
	base_keep_a: assert property ( // [RULE17]
		!apb_wr |=> $stable(base_cnt_reg) && $stable(base_tgt_reg) && $stable(base_req_reg))
		else $error("base changed without a write");
	reprog_clr_a: assert property ( // [RULE20]
		ctrl_wr |=> !empty_reg && !chain_refill_irq && !stopped_reg)
		else $error("reprogramming left flags set");
endmodule

// *** testbench/bus_resp.sv ***
// Purpose: byte bus responder standing in for requester or target memory
// Assumes: strobe held until ack, ack is a one-cycle pulse
// Notes:   read data depends on address; off-ack data toggles so stale bytes never match
module bus_resp #(
	parameter logic [7:0] SALT = 8'h00
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	// pacing, wait cycles before ack
	input  wire logic [1:0]  dly,
	// bus
	input  wire logic [31:0] addr,
	input  wire logic        stb,
	output logic      [7:0]  rdata,
	output logic             ack
);
	logic [1:0] wait_reg;
	wire        fire = stb && !ack && (wait_reg == dly);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_reg <= 2'h0;
			ack      <= 1'b0;
			rdata    <= 8'h00;
		end else begin
			ack      <= fire;
			rdata    <= fire ? (addr[7:0] ^ addr[15:8] ^ SALT) : ~rdata;
			wait_reg <= (stb && !ack && !fire) ? wait_reg + 2'h1 : 2'h0;
		end
	end
endmodule

// *** testbench/testbench.sv ***
// Purpose: self-checking bench for one dma channel
// Assumes: apb slave answers within a bounded wait
// Notes:   dreq is gated so the channel stops once the queued bytes are done
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic to_tgt; logic [31:0] a; logic [7:0] d;} xfer_s;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} rsp_s;
	localparam logic [7:0]  RSALT = 8'h3C;
	localparam logic [7:0]  TSALT = 8'hC3;
	localparam logic [31:0] ALL   = 32'hFFFFFFFF;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic        dreq = 1'b0, process_end_n = 1'b1, dreq_on = 1'b0, hold_req = 1'b0;
	logic [1:0]  dly = 2'h0;
	logic [31:0] prdata, req_addr, tgt_addr, seed = 32'h00000048, ra, ta, tb2, v;
	logic        pready, pslverr, req_stb, req_wr, req_ack, tgt_stb, tgt_wr, tgt_ack, chain_refill_irq;
	logic [7:0]  req_rdata, tgt_rdata, xfer_wdata;
	int          errors = 0, n_checks = 0, i;
	xfer_s       xq[$];
	rsp_s        rq[$];
	rsp_s        r_cur;
	dma_chan u_dma_chan (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dreq(dreq), .process_end_n(process_end_n), .req_addr(req_addr), .req_stb(req_stb), .req_wr(req_wr),
		.req_rdata(req_rdata), .req_ack(req_ack), .tgt_addr(tgt_addr), .tgt_stb(tgt_stb), .tgt_wr(tgt_wr),
		.tgt_rdata(tgt_rdata), .tgt_ack(tgt_ack), .xfer_wdata(xfer_wdata), .chain_refill_irq(chain_refill_irq));
	bus_resp #(.SALT(RSALT)) u_bus_resp (.ref_clk(ref_clk), .reset_n(reset_n), .dly(dly), .addr(req_addr),
		.stb(req_stb), .rdata(req_rdata), .ack(req_ack));
	bus_resp #(.SALT(TSALT)) u_bus_resp_tgt (.ref_clk(ref_clk), .reset_n(reset_n), .dly(dly), .addr(tgt_addr),
		.stb(tgt_stb), .rdata(tgt_rdata), .ack(tgt_ack));
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] stp(logic [31:0] a, logic [1:0] m);
		return (m == dma_chan_pkg::STEP_INC) ? a + 1 : ((m == dma_chan_pkg::STEP_DEC) ? a - 1 : a);
	endfunction
	function automatic logic [31:0] cw(logic en, logic dir, logic [1:0] pr, logic [1:0] rs, logic [1:0] ts);
		return {24'h0, ts, rs, pr, dir, en};
	endfunction
	task automatic print_verdict();
		if (errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [31:0] m, input logic e);
		int k;
		rq.push_back('{d, m, e});
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		// one idle edge so the next setup never reassigns psel in this time step
		@(posedge ref_clk);
		if (k == 20) begin
			chk("apb_timeout", 0, 1);
			print_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, a, d, s, 32'h0, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		apb(1'b0, a, d, 4'h0, m, 1'b0);
	endtask
	// base target address goes last of the base registers, before control, so its top byte marks the set full
	task automatic prog(input logic dir, input logic [1:0] pr, input logic [1:0] rs, input logic [1:0] ts,
			input logic [31:0] cnt);
		wr(dma_chan_pkg::OFS_BREQ, ra, 4'hF);
		wr(dma_chan_pkg::OFS_BCNT, cnt, 4'hF);
		wr(dma_chan_pkg::OFS_BTGT, ta, 4'hF);
		wr(dma_chan_pkg::OFS_CTRL, cw(1'b1, dir, pr, rs, ts), 4'hF);
	endtask
	task automatic plan(input logic dir, input logic [31:0] a, input logic [1:0] rs, input logic [31:0] t,
			input logic [1:0] ts, input int n);
		repeat (n) begin
			if (dir == dma_chan_pkg::DIR_READ) begin
				xq.push_back('{1'b0, a, t[7:0] ^ t[15:8] ^ TSALT});
			end else begin
				xq.push_back('{1'b1, t, a[7:0] ^ a[15:8] ^ RSALT});
			end
			a = stp(a, rs);
			t = stp(t, ts);
		end
	endtask
	task automatic run();
		int k;
		v = rnd();
		dly     <= v[1:0];
		dreq_on <= 1'b1;
		for (k = 0; k < 3000 && xq.size() > 0; k++) @(posedge ref_clk);
		if (xq.size() > 0) begin
			chk("xfer_timeout", 0, 1);
			print_verdict();
		end
		dreq_on <= 1'b0;
		repeat (6) @(posedge ref_clk);
	endtask
	// dreq held high with nothing queued: any byte moved is flagged
	task automatic idle(input int n);
		hold_req <= 1'b1;
		dreq_on  <= 1'b1;
		repeat (n) @(posedge ref_clk);
		dreq_on  <= 1'b0;
		hold_req <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic eop();
		process_end_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		process_end_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic take(input logic t, input logic [31:0] a);
		xfer_s x;
		if (xq.size() == 0) begin
			chk("xfer_unexpected", 0, 1);
			return;
		end
		x = xq.pop_front();
		chk("xfer_side", {31'h0, x.to_tgt}, {31'h0, t});
		chk("xfer_addr", x.a, a);
		chk("xfer_data", {24'h0, x.d}, {24'h0, xfer_wdata});
	endtask
	// the dreq gate sits here so it sees the queue after this edge's pops
	always @(posedge ref_clk) begin
		if (psel && penable && (pready === 1'b1)) begin
			r_cur = rq.pop_front();
			chk("prdata", r_cur.d & r_cur.m, prdata & r_cur.m);
			chk("pslverr", {31'h0, r_cur.e}, {31'h0, pslverr});
		end
		if ((req_stb === 1'b1) && req_wr && req_ack) take(1'b0, req_addr);
		if ((tgt_stb === 1'b1) && tgt_wr && tgt_ack) take(1'b1, tgt_addr);
		dreq <= dreq_on && (hold_req || xq.size() > 1 || (xq.size() == 1 && !(req_stb || tgt_stb)));
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		for (i = 0; i < 8; i++) rd(8'(4 * i), (i == 7) ? 32'h2 : 32'h0, ALL);
		apb(1'b0, 8'h20, 32'h0, 4'h0, ALL, 1'b1);
		wr(dma_chan_pkg::OFS_CCNT, 32'hFF, 4'hF);
		rd(dma_chan_pkg::OFS_CCNT, 32'h0, ALL);
		ra = rnd();
		ta = rnd();
		prog(dma_chan_pkg::DIR_READ, dma_chan_pkg::PROC_SINGLE, dma_chan_pkg::STEP_INC, dma_chan_pkg::STEP_DEC, 2);
		plan(1'b0, ra, dma_chan_pkg::STEP_INC, ta, dma_chan_pkg::STEP_DEC, 3);
		run();
		rd(dma_chan_pkg::OFS_STAT, 32'h2, 32'h3);
		rd(dma_chan_pkg::OFS_CREQ, ra + 3, ALL);
		rd(dma_chan_pkg::OFS_CTGT, ta - 3, ALL);
		rd(dma_chan_pkg::OFS_BREQ, ra, ALL);
		idle(30);
		prog(1'b1, dma_chan_pkg::PROC_SINGLE, dma_chan_pkg::STEP_DEC, 2'h2, 5);
		plan(1'b1, ra, dma_chan_pkg::STEP_DEC, ta, 2'h2, 1);
		run();
		eop();
		rd(dma_chan_pkg::OFS_STAT, 32'h2, 32'h3);
		idle(20);
		prog(1'b1, dma_chan_pkg::PROC_AUTO, 2'h3, dma_chan_pkg::STEP_INC, 1);
		for (i = 0; i < 3; i++) plan(1'b1, ra, 2'h3, ta, dma_chan_pkg::STEP_INC, (i == 2) ? 1 : 2);
		run();
		rd(dma_chan_pkg::OFS_CCNT, 32'h0, 32'hFFFFFF);
		eop();
		rd(dma_chan_pkg::OFS_CTGT, ta, ALL);
		rd(dma_chan_pkg::OFS_CCNT, 32'h1, 32'hFFFFFF);
		wr(dma_chan_pkg::OFS_CTRL, cw(1'b0, 1'b1, dma_chan_pkg::PROC_AUTO, 2'h0, 2'h0), 4'hF);
		idle(20);
		tb2 = rnd();
		prog(dma_chan_pkg::DIR_READ, dma_chan_pkg::PROC_CHAIN, dma_chan_pkg::STEP_INC, dma_chan_pkg::STEP_INC, 3);
		plan(1'b0, ra, dma_chan_pkg::STEP_INC, ta, dma_chan_pkg::STEP_INC, 1);
		run();
		eop();
		chk("chain_refill_irq", 32'h1, {31'h0, chain_refill_irq});
		rd(dma_chan_pkg::OFS_STAT, 32'hC, 32'hE);
		rd(dma_chan_pkg::OFS_CTGT, ta, ALL);
		wr(dma_chan_pkg::OFS_BTGT, tb2, 4'h7);
		chk("chain_refill_irq", 32'h1, {31'h0, chain_refill_irq});
		wr(dma_chan_pkg::OFS_BTGT, tb2, 4'hF);
		rd(dma_chan_pkg::OFS_STAT, 32'h0, 32'hC);
		plan(1'b0, ra, dma_chan_pkg::STEP_INC, ta, dma_chan_pkg::STEP_INC, 4);
		plan(1'b0, ra, dma_chan_pkg::STEP_INC, tb2, dma_chan_pkg::STEP_INC, 4);
		run();
		rd(dma_chan_pkg::OFS_STAT, 32'h2, 32'h3);
		idle(20);
		wr(dma_chan_pkg::OFS_CTRL, cw(1'b0, 1'b0, dma_chan_pkg::PROC_SINGLE, 2'h0, 2'h0), 4'hF);
		rd(dma_chan_pkg::OFS_STAT, 32'h0, 32'hC);
		chk("chain_refill_irq", 32'h0, {31'h0, chain_refill_irq});
		print_verdict();
	end
endmodule
